// [inc/lin_mode_consts.svh]
// Constants of the transceiver mode controller: register offsets, field positions,
// reset values and timing counts.
// Assumes a 10 MHz hclk and a 32-bit AHB-Lite register bus.
`ifndef LIN_MODE_CONSTS_SVH
`define LIN_MODE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define TICK_NS         1000
`define TICK_CYC        (`TICK_NS / `CLK_PERIOD_NS)
`define WAKE_QUAL_US    20
`define WAKE_QUAL_TICKS ((`WAKE_QUAL_US * 1000) / `TICK_NS)

// ----------------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------------
`define ADDR_CFG        8'h00
`define ADDR_STATUS     8'h04
`define CFG_EDGE_BIT    0
`define CFG_3V3_BIT     1
`define CFG_RST         32'h0000_0000
`define ST_MODE_LSB     0
`define ST_TXEN_BIT     4
`define ST_RXEN_BIT     5
`define ST_REGEN_BIT    6
`define ST_PULLUP_BIT   7
`define ST_REGFLT_BIT   8
`define ST_THERM_BIT    9
`define ST_STABLE_BIT   10

`endif

// [inc/lin_mode_pkg.sv]
// Types shared by the transceiver mode controller files.
// Assumes nothing beyond the constants header.
package lin_mode_pkg;

    // Operating modes of the transceiver.
    typedef enum logic [2:0] {
        MODE_POR,
        MODE_READY,
        MODE_OPER,
        MODE_TX_OFF,
        MODE_PDOWN
    } mode_e;

endpackage : lin_mode_pkg

// [rtl/tick_divider.sv]
// Free-running divider that gives a one-cycle enable every DIV cycles.
// Assumes hclk runs continuously, also in power-down.
`timescale 1ns/1ps
`include "lin_mode_consts.svh"
module tick_divider import lin_mode_pkg::*; #(
    parameter int DIV = `TICK_CYC,   // Cycles per tick.
    parameter int W   = 8            // Counter width.
) (
    input  wire logic hclk,     // System clock.
    input  wire logic hresetn,  // Asynchronous reset, active low.
    output logic      tick      // One-cycle enable pulse.
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] cnt;  // Cycles since last tick.
        logic         tick; // Registered tick.
    } div_s;
    div_s st_q, st_d;

    // Count up and wrap, pulsing on the wrap.
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == W'(DIV - 1)) begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + W'(1);
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule : tick_divider

// [rtl/bus_wake_filter.sv]
// Bus wake-up detector: qualifies a dominant bus level over a tick count.
// Assumes tick is a one-cycle enable from a free-running divider.
`timescale 1ns/1ps
`include "lin_mode_consts.svh"
module bus_wake_filter import lin_mode_pkg::*; #(
    parameter int QUAL = `WAKE_QUAL_TICKS,  // Ticks of dominant level needed.
    parameter int W    = 6                  // Counter width.
) (
    input  wire logic hclk,      // System clock.
    input  wire logic hresetn,   // Asynchronous reset, active low.
    input  wire logic tick,      // Timebase enable.
    input  wire logic enable,    // Detector armed (power-down only).
    input  wire logic edge_mode, // Require recessive-to-dominant first.
    input  wire logic dominant,  // Bus line is dominant.
    output logic      wake       // One-cycle wake request.
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] cnt;    // Dominant ticks counted.
        logic         armed;  // Recessive seen since enable.
        logic         wake;   // Registered wake pulse.
    } wf_s;
    wf_s st_q, st_d;

    // A stuck-dominant bus never arms the edge variant, so it can still sleep.
    always_comb begin
        st_d = st_q;
        st_d.wake = 1'b0;
        if (!enable) begin
            st_d = '0;
        end else if (!dominant) begin
            st_d.cnt   = '0;
            st_d.armed = 1'b1;
        end else if ((st_q.armed || !edge_mode) && tick) begin
            if (st_q.cnt == W'(QUAL - 1)) begin
                st_d.wake  = 1'b1;
                st_d.cnt   = '0;
                st_d.armed = 1'b0;
            end else begin
                st_d.cnt = st_q.cnt + W'(1);
            end
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign wake = st_q.wake;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_wake_qualified: assert property (wake |-> $past(dominant) && $past(enable))
        else $error("Wake without a qualified dominant level.");
endmodule : bus_wake_filter

// [rtl/lin_transceiver_mode_control.sv]
// Mode state machine of a single-wire bus transceiver with integrated regulator.
// Assumes supply and regulator comparators arrive as flags on hclk, except the asynchronous regulator-stable flag; pins are synchronous.
// Contract
// - Hold reset in POR until supply above on-threshold.
// - Supply below off-threshold returns to POR.
// - Power-down: transmitter, regulator off; wake detectors on.
// - Wake pin high in power-down: ready, regulator on.
// - Pin wake proceeds after regulator stable.
// - Bus activity wakes; level variant on dominant.
// - Edge variant needs edge plus 20 us dominant.
// - Power-down only from operation or transmitter-off.
// - Ready: regulator, receiver on, transmitter off.
// - Ready bus recessive, or floating in edge variant.
// - Leave ready on stable regulator and wake pin.
// - Edge variant picks mode from enable pin.
// - Operation: all on; wake pin fall sleeps.
// - Edge variant pull-up only in operation.
// - Regulator off below its turn-off level.
// - Thermal overload stops transmitter and regulator.
// - Transmitter off on enable low or stuck dominant.
// - Enable pin cannot override internal fault.
// - Enable low selects transmitter-off, high operation.
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "lin_mode_consts.svh"
module lin_transceiver_mode_control import lin_mode_pkg::*; (
    input  wire logic        hclk,                 // System clock, 10 MHz.
    input  wire logic        hresetn,              // Asynchronous reset, active low.
    input  wire logic        hsel,                 // AHB slave select.
    input  wire logic [7:0]  haddr,                // AHB byte address.
    input  wire logic [1:0]  htrans,               // AHB transfer type.
    input  wire logic        hwrite,               // AHB write strobe.
    input  wire logic [2:0]  hsize,                // AHB transfer size.
    input  wire logic [31:0] hwdata,               // AHB write data.
    input  wire logic        hready,               // AHB bus ready.
    output logic             hreadyout,            // AHB slave ready.
    output logic             hresp,                // AHB response, always OKAY.
    output logic [31:0]      hrdata,               // AHB read data.
    input  wire logic        supply_above_on,      // Battery supply above on-threshold.
    input  wire logic        supply_below_off,     // Battery supply below off-threshold.
    input  wire logic        vreg_stable,          // Regulator output stable (async).
    input  wire logic        vreg_below_3v5,       // Regulator output below 3.5 V.
    input  wire logic        vreg_below_2v5,       // Regulator output below 2.5 V.
    input  wire logic        thermal_overload,     // Thermal shutdown sensor.
    input  wire logic        perm_dominant,        // Stuck dominant on transmit or bus.
    input  wire logic        wake_select_pin,      // Wake/select pin level.
    input  wire logic        bus_dominant,         // Bus line pin reads dominant.
    input  wire logic        fault_tx_enable_pin_i,// Fault/transmit-enable pin level.
    output logic             fault_tx_enable_pin_o,// Fault pin drive value.
    output logic             fault_tx_enable_pin_oe,// Fault pin pulled low by device.
    output logic             digital_reset,        // Digital section held in reset.
    output logic             tx_enable,            // Bus transmitter enabled.
    output logic             rx_enable,            // Receiver enabled.
    output logic             reg_enable,           // Regulator enabled.
    output logic             pullup_enable,        // Bus pull-up connected.
    output logic             wake_det_enable       // Bus wake detector powered.
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    // Every flip-flop of this module lives in one struct.
    typedef struct packed {
        mode_e       mode;       // Current operating mode.
        logic        stab_m;     // Regulator-stable, first sync stage.
        logic        stab_s;     // Regulator-stable, synchronized.
        logic        wake_prev;  // Wake pin one cycle ago.
        logic        reg_fault;  // Regulator dropped below turn-off.
        logic [31:0] cfg;        // Configuration register.
        logic        wr_pend;    // Write data phase pending.
        logic [7:0]  wr_addr;    // Address of pending write.
        logic [31:0] rdata;      // Registered read data.
    } st_s;
    st_s st_q, st_d;

    logic tick;      // One microsecond enable.
    logic bus_wake;  // Qualified bus wake request.

    // Configuration fields decoded once.
    logic edge_var;  // Edge-wake variant selected.
    logic opt_3v3;   // 3.3 V regulator option.
    assign edge_var = st_q.cfg[`CFG_EDGE_BIT];
    assign opt_3v3  = st_q.cfg[`CFG_3V3_BIT];

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Modes in which the regulator and receiver are powered.
    function automatic logic mode_active(input mode_e m);
        return (m == MODE_READY) || (m == MODE_OPER) || (m == MODE_TX_OFF);
    endfunction : mode_active

    // Mode chosen when leaving ready mode.
    function automatic mode_e ready_exit(input logic edge_v, input logic txe);
        return (edge_v && !txe) ? MODE_TX_OFF : MODE_OPER;
    endfunction : ready_exit

    // ------------------------------------------------------------------------
    // Fault and output terms
    // ------------------------------------------------------------------------
    logic vreg_low;       // Regulator below the selected turn-off level.
    logic int_fault;      // Any internal condition blocking the transmitter.
    logic shut_reg;       // Regulator forced off.
    // The turn-off comparator depends on the regulator option.
    assign vreg_low  = opt_3v3 ? vreg_below_2v5 : vreg_below_3v5;
    assign shut_reg  = thermal_overload || st_q.reg_fault;
    // Transmitter also stays off while the regulator is unsettled.
    assign int_fault = perm_dominant || shut_reg || !st_q.stab_s;

    // The fault pin is pulled low while an internal fault holds in ready, operation or
    // transmitter-off mode, so a host raising it cannot re-enable the transmitter.
    assign fault_tx_enable_pin_o  = 1'b0;
    assign fault_tx_enable_pin_oe = mode_active(st_q.mode) && int_fault;

    assign digital_reset   = (st_q.mode == MODE_POR);
    assign rx_enable       = mode_active(st_q.mode);
    assign reg_enable      = mode_active(st_q.mode) && !shut_reg;
    assign tx_enable       = (st_q.mode == MODE_OPER) && fault_tx_enable_pin_i
                             && !int_fault;
    assign wake_det_enable = (st_q.mode == MODE_PDOWN);
    // Level variant keeps its pull-up, so ready is recessive; edge floats.
    assign pullup_enable   = edge_var ? (st_q.mode == MODE_OPER) : 1'b1;

    // ------------------------------------------------------------------------
    // Timebase and bus wake detector
    // ------------------------------------------------------------------------
    tick_divider u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick)
    );

    bus_wake_filter u_wake (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .tick      (tick),
        .enable    (wake_det_enable),
        .edge_mode (edge_var),
        .dominant  (bus_dominant),
        .wake      (bus_wake)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    logic addr_ok;  // Bus address phase accepted.
    assign addr_ok = hsel && hready && htrans[1];

    // Mode machine, fault latch, synchronizer and register slave.
    always_comb begin
        st_d = st_q;
        // Regulator-stable is asynchronous to hclk.
        st_d.stab_m    = vreg_stable;
        st_d.stab_s    = st_q.stab_m;
        st_d.wake_prev = wake_select_pin;

        // A drop below turn-off after the output was good latches it off.
        if (!mode_active(st_q.mode)) begin
            st_d.reg_fault = 1'b0;
        end else if (st_q.stab_s && vreg_low) begin
            st_d.reg_fault = 1'b1;
        end

        if (supply_below_off) begin
            st_d.mode = MODE_POR;
        end else begin
            unique case (st_q.mode)
                MODE_POR: begin
                    if (supply_above_on) begin
                        st_d.mode = MODE_READY;
                    end
                end
                MODE_READY: begin
                    // Waits for a stable regulator; never sleeps from here.
                    if (st_q.stab_s && wake_select_pin) begin
                        st_d.mode = ready_exit(edge_var, fault_tx_enable_pin_i);
                    end
                end
                MODE_OPER: begin
                    if (st_q.wake_prev && !wake_select_pin) begin
                        st_d.mode = MODE_PDOWN;
                    end else if (!fault_tx_enable_pin_i || perm_dominant) begin
                        st_d.mode = MODE_TX_OFF;
                    end
                end
                MODE_TX_OFF: begin
                    if (!wake_select_pin) begin
                        st_d.mode = MODE_PDOWN;
                    end else if (fault_tx_enable_pin_i && !int_fault) begin
                        st_d.mode = MODE_OPER;
                    end
                end
                MODE_PDOWN: begin
                    if (wake_select_pin || bus_wake) begin
                        st_d.mode = MODE_READY;
                    end
                end
                default: begin
                    st_d.mode = MODE_POR;
                end
            endcase
        end

        // Register slave: data phase of a write stores the word.
        st_d.wr_pend = 1'b0;
        if (st_q.wr_pend && st_q.wr_addr == `ADDR_CFG) begin
            st_d.cfg = hwdata;
        end
        if (addr_ok && hwrite) begin
            st_d.wr_pend = 1'b1;
            st_d.wr_addr = haddr;
        end
        // Reads are sampled at the address phase; unmapped words read zero.
        if (addr_ok && !hwrite) begin
            st_d.rdata = 32'h0000_0000;
            if (haddr == `ADDR_CFG) begin
                st_d.rdata = st_q.cfg;
            end else if (haddr == `ADDR_STATUS) begin
                st_d.rdata[`ST_MODE_LSB +: 3] = st_q.mode;
                st_d.rdata[`ST_TXEN_BIT]      = tx_enable;
                st_d.rdata[`ST_RXEN_BIT]      = rx_enable;
                st_d.rdata[`ST_REGEN_BIT]     = reg_enable;
                st_d.rdata[`ST_PULLUP_BIT]    = pullup_enable;
                st_d.rdata[`ST_REGFLT_BIT]    = st_q.reg_fault;
                st_d.rdata[`ST_THERM_BIT]     = thermal_overload;
                st_d.rdata[`ST_STABLE_BIT]    = st_q.stab_s;
            end
        end
    end

    // State register; reset lands in power-on reset mode.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q      <= '0;
            st_q.mode <= MODE_POR;
            st_q.cfg  <= `CFG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Zero wait states, always OKAY; hsize is accepted as a word.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_q.rdata;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Ready mode with both exit conditions met.
    sequence ready_go;
        st_q.mode == MODE_READY && st_q.stab_s && wake_select_pin && !supply_below_off;
    endsequence

    chk_por_on_brownout: assert property (supply_below_off |=> st_q.mode == MODE_POR)
        else $error("No return to POR on low supply.");
    chk_por_exit_ready: assert property (st_q.mode == MODE_POR
        && supply_above_on && !supply_below_off |=> st_q.mode == MODE_READY)
        else $error("POR did not move to ready.");
    chk_pdown_outputs: assert property (st_q.mode == MODE_PDOWN
        |-> !tx_enable && !reg_enable && wake_det_enable)
        else $error("Power-down outputs wrong.");
    chk_pin_wake_ready: assert property (st_q.mode == MODE_PDOWN && wake_select_pin
        && !supply_below_off |=> st_q.mode == MODE_READY)
        else $error("Wake pin did not wake.");
    chk_pdown_entry: assert property ($changed(st_q.mode) && st_q.mode == MODE_PDOWN
        |-> $past(st_q.mode) inside {MODE_OPER, MODE_TX_OFF})
        else $error("Power-down entered from a wrong mode.");
    chk_ready_no_tx: assert property (st_q.mode == MODE_READY
        |-> !tx_enable && rx_enable)
        else $error("Ready mode transmitter state wrong.");
    chk_ready_waits: assert property (st_q.mode == MODE_READY && !st_q.stab_s
        |=> st_q.mode inside {MODE_READY, MODE_POR})
        else $error("Ready left before regulator stable.");
    chk_level_exit: assert property (ready_go ##0 !edge_var
        |=> st_q.mode == MODE_OPER)
        else $error("Level variant did not enter operation.");
    chk_edge_exit: assert property (ready_go ##0 edge_var ##0 !fault_tx_enable_pin_i
        |=> st_q.mode == MODE_TX_OFF)
        else $error("Edge variant did not enter transmitter-off.");
    chk_oper_fall_sleep: assert property (st_q.mode == MODE_OPER
        && $fell(wake_select_pin) && !supply_below_off |=> st_q.mode == MODE_PDOWN)
        else $error("Falling wake pin did not sleep.");
    chk_pullup_edge: assert property (edge_var && st_q.mode != MODE_OPER
        |-> !pullup_enable)
        else $error("Pull-up connected outside operation.");
    chk_thermal_off: assert property (thermal_overload |-> !tx_enable && !reg_enable)
        else $error("Thermal overload left outputs on.");
    chk_txe_low_off: assert property (!fault_tx_enable_pin_i || perm_dominant
        |-> !tx_enable)
        else $error("Transmitter on with enable low.");
    chk_bus_wake_ready: assert property (st_q.mode == MODE_PDOWN && bus_wake
        && !supply_below_off |=> st_q.mode == MODE_READY)
        else $error("Bus wake did not reach ready.");
    chk_oper_all_on: assert property (st_q.mode == MODE_OPER && !shut_reg
        |-> rx_enable && reg_enable)
        else $error("Operation mode left a function off.");
    chk_reg_fault_off: assert property (st_q.reg_fault
        |-> !reg_enable && !tx_enable)
        else $error("Regulator fault left outputs on.");
    chk_fault_pin_low: assert property (mode_active(st_q.mode)
        && (thermal_overload || perm_dominant) |-> fault_tx_enable_pin_oe
        && !fault_tx_enable_pin_o)
        else $error("Fault pin not pulled low on internal fault.");
endmodule : lin_transceiver_mode_control

// [verif/host_pins.sv]
// Host side of the mode pins: wake/select drive and the shared fault/enable line.
// Assumes the testbench sets the host's wishes; the line has a pull-up.
`timescale 1ns/1ps
module host_pins (
    input  wire logic host_wake,       // Host wish for the wake/select pin.
    input  wire logic host_txe,        // Host wish for the enable line.
    input  wire logic dev_o,           // Device drive value on the line.
    input  wire logic dev_oe,          // Device pulls the line.
    output logic      wake_select_pin, // Wake/select pin level.
    output logic      fault_pin        // Resolved enable line level.
);
    // The device's pull-down wins, so a host high cannot mask a fault.
    assign wake_select_pin = host_wake;
    assign fault_pin       = dev_oe ? dev_o : host_txe;
endmodule : host_pins

// [verif/lin_transceiver_mode_control_test.sv]
// Self-checking bench of the transceiver mode controller.
// Assumes a zero-wait register slave and comparator flags on hclk.
`timescale 1ns/1ps
`include "lin_mode_consts.svh"
module lin_transceiver_mode_control_test import lin_mode_pkg::*;;
    typedef struct packed {logic w; logic t; logic d; logic [8:0] n; logic [7:0] e;} row_s;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;  // Bus control.
    logic [7:0]  haddr = '0;                                   // Bus address.
    logic [1:0]  htrans = '0;                                  // Bus transfer type.
    logic [31:0] hwdata = '0, hrdata, rd;                      // Bus data.
    logic        sup_on = 1, sup_off = 0, therm = 0, dom = 0;  // Analog flags.
    logic        stab = 1, perm = 0, v35 = 0, v25 = 0;         // Regulator and fault flags.
    logic        host_wake = 0, host_txe = 1;                  // Host wishes.
    logic        hreadyout, hresp, wpin, fpin, f_o, f_oe;      // Pins.
    logic        dig_rst, tx_en, rx_en, reg_en, pu_en, wd_en;  // Mode outputs.
    int          num_errors = 0, comparisons = 0;              // Score.
    // Level variant walk; status low byte is pullup,reg,rx,tx,0,mode.
    row_s rows [10] = '{'{0,1,0,5,8'he1}, '{1,1,0,5,8'hf2}, '{1,0,0,5,8'he3},
        '{1,1,0,5,8'hf2}, '{0,1,0,5,8'h84}, '{0,1,1,300,8'he1}, '{0,1,0,5,8'he1},
        '{1,1,0,5,8'hf2}, '{0,1,0,5,8'h84}, '{1,1,0,5,8'hf2}};
    always #50 hclk = ~hclk;
    lin_transceiver_mode_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .supply_above_on(sup_on), .supply_below_off(sup_off), .vreg_stable(stab),
        .vreg_below_3v5(v35), .vreg_below_2v5(v25), .thermal_overload(therm),
        .perm_dominant(perm), .wake_select_pin(wpin), .bus_dominant(dom),
        .fault_tx_enable_pin_i(fpin), .fault_tx_enable_pin_o(f_o),
        .fault_tx_enable_pin_oe(f_oe), .digital_reset(dig_rst), .tx_enable(tx_en),
        .rx_enable(rx_en), .reg_enable(reg_en), .pullup_enable(pu_en),
        .wake_det_enable(wd_en));
    host_pins hp (.host_wake(host_wake), .host_txe(host_txe), .dev_o(f_o),
        .dev_oe(f_oe), .wake_select_pin(wpin), .fault_pin(fpin));
    // One single transfer; called just after a rising edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    // Compare and count.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Set pins, let the mode settle, then read status.
    task automatic step(input logic w, input logic t, input int n);
        host_wake <= w;
        host_txe  <= t;
        repeat (n) @(posedge hclk);
        bus(1'b0, `ADDR_STATUS, 32'h0000_0000, rd);
    endtask : step
    // Single place where the run ends.
    task automatic test_done();
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // Main sequence: table walk first, then the edge variant and faults.
    initial begin
        repeat (4) @(posedge hclk);
        check("digital_reset", dig_rst, 32'h0000_0001);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            dom <= rows[i].d;
            step(rows[i].w, rows[i].t, rows[i].n);
            check("status", rd[7:0], rows[i].e);
        end
        bus(1'b1, `ADDR_CFG, 32'h0000_0001, rd);
        bus(1'b0, `ADDR_CFG, 32'h0000_0000, rd);
        check("cfg", rd, 32'h0000_0001);
        step(1'b0, 1'b1, 5);
        check("status", rd[7:0], 8'h04);
        step(1'b1, 1'b0, 5);
        check("status", rd[7:0], 8'h63);
        therm <= 1'b1;
        step(1'b1, 1'b1, 5);
        check("status", rd[11:0], 32'h0000_0623);
        check("fault_pin", fpin, 32'h0000_0000);
        bus(1'b0, 8'h08, 32'h0000_0000, rd);
        check("unmapped", rd, 32'h0000_0000);
        // Stuck dominant holds the transmitter off; its end lets it back on.
        therm <= 1'b0;
        perm  <= 1'b1;
        step(1'b1, 1'b1, 5);
        check("status", rd[7:0], 8'h63);
        perm <= 1'b0;
        step(1'b1, 1'b1, 5);
        check("status", rd[7:0], 8'hf2);
        // The 3.3 V option ignores the 3.5 V comparator and trips at 2.5 V.
        bus(1'b1, `ADDR_CFG, 32'h0000_0003, rd);
        v35 <= 1'b1;
        step(1'b1, 1'b1, 5);
        check("status", rd[11:0], 32'h0000_04f2);
        v25 <= 1'b1;
        step(1'b1, 1'b1, 5);
        check("status", rd[11:0], 32'h0000_0523);
        // Edge variant asleep on a stuck dominant bus must stay asleep.
        v35 <= 1'b0;
        v25 <= 1'b0;
        dom <= 1'b1;
        step(1'b0, 1'b1, 300);
        check("status", rd[11:0], 32'h0000_0404);
        dom <= 1'b0;
        step(1'b0, 1'b1, 5);
        check("status", rd[7:0], 8'h04);
        dom <= 1'b1;
        step(1'b0, 1'b1, 300);
        check("status", rd[11:0], 32'h0000_0461);
        // Ready holds until the regulator is stable again.
        stab <= 1'b0;
        step(1'b0, 1'b1, 5);
        check("status", rd[11:0], 32'h0000_0061);
        step(1'b1, 1'b1, 5);
        check("status", rd[11:0], 32'h0000_0061);
        stab <= 1'b1;
        step(1'b1, 1'b1, 5);
        check("status", rd[11:0], 32'h0000_04f2);
        sup_off <= 1'b1;
        repeat (5) @(posedge hclk);
        check("digital_reset", dig_rst, 32'h0000_0001);
        test_done();
    end
    // Watchdog: the whole walk needs well under two thousand cycles.
    initial begin
        #3_000_000;
        num_errors++;
        test_done();
    end
endmodule : lin_transceiver_mode_control_test
